/* File: include/ccb_defs.svh */
// Opcodes, PC step, BCD constants and timing counts of the compare/clear/invert/adjust unit
`ifndef CCB_DEFS_SVH
`define CCB_DEFS_SVH

`define CCB_OP_CMP_ACC_IMM   8'hB4
`define CCB_OP_CMP_ACC_DIR   8'hB5
`define CCB_OP_CMP_IND_HI    7'h5B
`define CCB_OP_CMP_REG_HI    5'h17
`define CCB_OP_CLR_ACC       8'hE4
`define CCB_OP_CLR_CARRY     8'hC3
`define CCB_OP_CLR_BIT       8'hC2
`define CCB_OP_INV_ACC       8'hF4
`define CCB_OP_INV_CARRY     8'hB3
`define CCB_OP_INV_BIT       8'hB2
`define CCB_OP_DEC_ADJ       8'hD4

`define CCB_PC_STEP_CMP      16'h0003
`define CCB_BCD_FIX          4'h6
`define CCB_BCD_MAX          4'h9
`define CCB_MCYC_CMP         2'h2
`define CCB_MCYC_ONE         2'h1
`define CCB_MCYC_CLKS        8'h0C

`endif

/* File: include/ccb_pkg.sv */
// Types shared by the compare/clear/invert/adjust unit
`default_nettype none
package ccb_pkg;
    typedef enum logic {CCB_IDLE, CCB_EXEC} ccb_state_t;

    typedef struct packed {
        ccb_state_t  state;
        logic [7:0]  div;
        logic [1:0]  mcyc;
        logic [1:0]  need;
        logic [7:0]  acc;
        logic        carry;
        logic        bit_val;
        logic [7:0]  bit_addr;
        logic [15:0] pc;
        logic        acc_we;
        logic        c_we;
        logic        bit_we;
        logic        pc_we;
        logic        done;
    } ccb_st_t;
endpackage
`default_nettype wire

/* File: hdl/ccb_bcd_adj.sv */
// Two-step decimal adjust of the accumulator after a packed-BCD addition
`include "ccb_defs.svh"
`default_nettype none
module ccb_bcd_adj (
    input  wire logic [7:0] acc_i,
    input  wire logic       carry_i,
    input  wire logic       aux_carry_flag_i,
    output logic      [7:0] acc_o,
    output logic            carry_o
);
    logic [8:0] low_sum;
    logic [8:0] high_sum;
    logic       c_mid;

    always_comb begin
        low_sum = {1'b0, acc_i};
        if (acc_i[3:0] > `CCB_BCD_MAX || aux_carry_flag_i) begin
            low_sum = {1'b0, acc_i} + {5'h00, `CCB_BCD_FIX};
        end
        c_mid = carry_i | low_sum[8];
        // high nibble fix, carry only ever set
        high_sum = {1'b0, low_sum[7:0]};
        if (low_sum[7:4] > `CCB_BCD_MAX || c_mid) begin
            high_sum = {1'b0, low_sum[7:0]} + {1'b0, `CCB_BCD_FIX, 4'h0};
        end
        acc_o   = high_sum[7:0];
        carry_o = c_mid | high_sum[8];
    end
endmodule // ccb_bcd_adj
`default_nettype wire

/* File: hdl/ccb_core.sv */
// Execution unit for compare-branch, clear, invert and decimal adjust
`include "ccb_defs.svh"
`default_nettype none
module ccb_core #(
    parameter logic [7:0] MCYC_CLKS = `CCB_MCYC_CLKS
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [7:0]  byte2_i,
    input  wire logic [7:0]  byte3_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  acc_i,
    input  wire logic [7:0]  wreg_i,
    input  wire logic [7:0]  ind_data_i,
    input  wire logic [7:0]  dir_data_i,
    input  wire logic        carry_i,
    input  wire logic        aux_carry_flag_i,
    input  wire logic        bit_mem_i,
    input  wire logic        bit_latch_i,
    input  wire logic        bit_is_port_i,
    output logic             ready_o,
    output logic [2:0]       working_register_o,
    output logic             pointer_register_o,
    output logic [7:0]       dir_addr_o,
    output logic [7:0]       acc_o,
    output logic             acc_we_o,
    output logic             carry_o,
    output logic             carry_we_o,
    output logic [7:0]       bit_addr_o,
    output logic             bit_val_o,
    output logic             bit_we_o,
    output logic [15:0]      pc_o,
    output logic             pc_we_o,
    output logic             done_o
);
    ccb_pkg::ccb_st_t st_reg;
    ccb_pkg::ccb_st_t st_next;

    logic       is_cmp;
    logic       is_known;
    logic       take;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic       bit_orig;
    logic [7:0] da_acc;
    logic       da_carry;

    assign working_register_o = opcode_i[2:0];
    assign pointer_register_o = opcode_i[0];
    assign dir_addr_o         = byte2_i;
    assign ready_o            = (st_reg.state == ccb_pkg::CCB_IDLE);

    assign is_cmp = (opcode_i == `CCB_OP_CMP_ACC_IMM) || (opcode_i == `CCB_OP_CMP_ACC_DIR)
                 || (opcode_i[7:1] == `CCB_OP_CMP_IND_HI)
                 || (opcode_i[7:3] == `CCB_OP_CMP_REG_HI);
    assign is_known = is_cmp || (opcode_i == `CCB_OP_CLR_ACC)
                   || (opcode_i == `CCB_OP_CLR_CARRY) || (opcode_i == `CCB_OP_CLR_BIT)
                   || (opcode_i == `CCB_OP_INV_ACC) || (opcode_i == `CCB_OP_INV_CARRY)
                   || (opcode_i == `CCB_OP_INV_BIT) || (opcode_i == `CCB_OP_DEC_ADJ);
    // Unknown opcodes are left to other units and simply not taken
    assign take = start_i && ready_o && is_known;

    always_comb begin
        op_a = acc_i;
        op_b = byte2_i;
        // indirect form uses the byte at the pointer
        if (opcode_i[7:1] == `CCB_OP_CMP_IND_HI) begin
            op_a = ind_data_i;
        end else if (opcode_i[7:3] == `CCB_OP_CMP_REG_HI) begin
            op_a = wreg_i;
        end else if (opcode_i == `CCB_OP_CMP_ACC_DIR) begin
            op_b = dir_data_i;
        end
    end

    // port bits read from the output latch
    assign bit_orig = bit_is_port_i ? bit_latch_i : bit_mem_i;

    ccb_bcd_adj u_bcd_adj (
        .acc_i            (acc_i),
        .carry_i          (carry_i),
        .aux_carry_flag_i (aux_carry_flag_i),
        .acc_o            (da_acc),
        .carry_o          (da_carry)
    );

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        case (st_reg.state)
            ccb_pkg::CCB_IDLE: begin
                if (take) begin
                    st_next.state    = ccb_pkg::CCB_EXEC;
                    st_next.div      = 8'h00;
                    st_next.mcyc     = 2'h0;
                    st_next.need     = is_cmp ? `CCB_MCYC_CMP : `CCB_MCYC_ONE;
                    st_next.bit_addr = byte2_i;
                    case (opcode_i)
                        `CCB_OP_CLR_ACC:   st_next.acc = 8'h00;
                        `CCB_OP_INV_ACC:   st_next.acc = ~acc_i;
                        `CCB_OP_CLR_CARRY: st_next.carry = 1'b0;
                        `CCB_OP_INV_CARRY: st_next.carry = ~carry_i;
                        `CCB_OP_CLR_BIT:   st_next.bit_val = 1'b0;
                        `CCB_OP_INV_BIT:   st_next.bit_val = ~bit_orig;
                        // both fixes in one step, overflow untouched
                        `CCB_OP_DEC_ADJ: begin
                            st_next.acc   = da_acc;
                            st_next.carry = da_carry;
                        end
                        default: begin
                            st_next.carry = (op_a < op_b);
                            // advance by 3, then branch on inequality
                            st_next.pc = pc_i + `CCB_PC_STEP_CMP;
                            if (op_a != op_b) begin
                                st_next.pc = pc_i + `CCB_PC_STEP_CMP
                                           + {{8{byte3_i[7]}}, byte3_i};
                            end
                        end
                    endcase
                    // Enables held until done, replaced at the next take
                    st_next.acc_we = (opcode_i == `CCB_OP_CLR_ACC)
                                  || (opcode_i == `CCB_OP_INV_ACC)
                                  || (opcode_i == `CCB_OP_DEC_ADJ);
                    st_next.c_we   = is_cmp || (opcode_i == `CCB_OP_CLR_CARRY)
                                  || (opcode_i == `CCB_OP_INV_CARRY)
                                  || (opcode_i == `CCB_OP_DEC_ADJ);
                    // compare writes only carry and PC
                    st_next.bit_we = (opcode_i == `CCB_OP_CLR_BIT)
                                  || (opcode_i == `CCB_OP_INV_BIT);
                    st_next.pc_we  = is_cmp;
                end
            end
            ccb_pkg::CCB_EXEC: begin
                st_next.div = st_reg.div + 8'h01;
                if (st_reg.div == MCYC_CLKS - 8'h01) begin
                    st_next.div  = 8'h00;
                    st_next.mcyc = st_reg.mcyc + 2'h1;
                    // results land at the end of the last machine cycle
                    if (st_reg.mcyc + 2'h1 == st_reg.need) begin
                        st_next.state = ccb_pkg::CCB_IDLE;
                        st_next.done  = 1'b1;
                    end
                end
            end
            default: st_next.state = ccb_pkg::CCB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign acc_o      = st_reg.acc;
    assign carry_o    = st_reg.carry;
    assign bit_addr_o = st_reg.bit_addr;
    assign bit_val_o  = st_reg.bit_val;
    assign pc_o       = st_reg.pc;
    assign done_o     = st_reg.done;
    assign acc_we_o   = st_reg.done & st_reg.acc_we;
    assign carry_we_o = st_reg.done & st_reg.c_we;
    assign bit_we_o   = st_reg.done & st_reg.bit_we;
    assign pc_we_o    = st_reg.done & st_reg.pc_we;

    // Clocks since the last take, for the duration checks
    logic [9:0] run_cnt;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            run_cnt <= 10'h000;
        end else if (take) begin
            run_cnt <= 10'h000;
        end else begin
            run_cnt <= run_cnt + 10'h001;
        end
    end

    a_cmp_carry_value:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && is_cmp |=> st_reg.carry == ($past(op_a) < $past(op_b)))
        else $error("compare carry wrong");
    a_cmp_pc_target:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && is_cmp |=> st_reg.pc == $past(pc_i) + 16'h0003
                + (($past(op_a) != $past(op_b)) ? {{8{$past(byte3_i[7])}}, $past(byte3_i)}
                                                 : 16'h0000))
        else $error("compare branch target wrong");
    a_cmp_two_cycles:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            done_o && pc_we_o |-> run_cnt == {2'h0, MCYC_CLKS} + {2'h0, MCYC_CLKS})
        else $error("compare did not take two machine cycles");
    a_cmp_no_writes:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            pc_we_o |-> carry_we_o && !acc_we_o && !bit_we_o)
        else $error("compare wrote an operand");
    a_one_cycle_ops:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            done_o && !pc_we_o |-> run_cnt == {2'h0, MCYC_CLKS})
        else $error("single-cycle op took wrong time");
    a_clr_acc_zero:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == `CCB_OP_CLR_ACC |=> st_reg.acc == 8'h00 && !st_reg.c_we)
        else $error("clear accumulator failed");
    a_inv_acc_value:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == `CCB_OP_INV_ACC |=> st_reg.acc == ~$past(acc_i) && !st_reg.c_we)
        else $error("invert accumulator failed");
    a_inv_bit_latch:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == 8'hB2 && bit_is_port_i |=> st_reg.bit_val == !$past(bit_latch_i))
        else $error("invert bit did not use latch");
    a_clr_bit_zero:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == `CCB_OP_CLR_BIT |=> !st_reg.bit_val
                && {st_reg.pc_we, st_reg.bit_we, st_reg.c_we, st_reg.acc_we} == 4'h4)
        else $error("clear bit failed");
    a_da_carry_kept:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == 8'hD4 && carry_i |=> st_reg.carry)
        else $error("decimal adjust cleared carry");
    a_da_low_fix:
        assert property (@(posedge ref_clk_i) disable iff (rst_i)
            take && opcode_i == 8'hD4 && acc_i == 8'h0A && !carry_i
            |=> st_reg.acc == 8'h10 && !st_reg.carry)
        else $error("decimal adjust low fix wrong");
endmodule // ccb_core
`default_nettype wire

/* File: test/ccb_core_tb.sv */
// Self-checking bench for the compare/clear/invert/adjust unit
`include "ccb_defs.svh"
`default_nettype none
module ccb_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // Short machine cycle keeps the run brief
    localparam logic [7:0] MC = 8'h02;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        start_i = 1'b0;
    logic [7:0]  opcode_i = 8'h00, byte2_i = 8'h00, byte3_i = 8'h00, acc_i = 8'h00;
    logic [7:0]  wreg_i = 8'h00, ind_data_i = 8'h00, dir_data_i = 8'h00;
    logic [15:0] pc_i = 16'h0000;
    logic        carry_i = 1'b0, aux_carry_flag_i = 1'b0;
    logic        bit_mem_i = 1'b0, bit_latch_i = 1'b0, bit_is_port_i = 1'b0;
    logic        ready_o, pointer_register_o, acc_we_o, carry_o, carry_we_o;
    logic        bit_val_o, bit_we_o, pc_we_o, done_o;
    logic [2:0]  working_register_o;
    logic [7:0]  dir_addr_o, acc_o, bit_addr_o;
    logic [15:0] pc_o;
    int          n_fail = 0;
    int          compares = 0;

    ccb_core #(.MCYC_CLKS(MC)) u_ccb_core (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_i), .opcode_i(opcode_i),
        .byte2_i(byte2_i), .byte3_i(byte3_i), .pc_i(pc_i), .acc_i(acc_i), .wreg_i(wreg_i),
        .ind_data_i(ind_data_i), .dir_data_i(dir_data_i), .carry_i(carry_i),
        .aux_carry_flag_i(aux_carry_flag_i), .bit_mem_i(bit_mem_i),
        .bit_latch_i(bit_latch_i), .bit_is_port_i(bit_is_port_i), .ready_o(ready_o),
        .working_register_o(working_register_o), .pointer_register_o(pointer_register_o),
        .dir_addr_o(dir_addr_o), .acc_o(acc_o), .acc_we_o(acc_we_o), .carry_o(carry_o),
        .carry_we_o(carry_we_o), .bit_addr_o(bit_addr_o), .bit_val_o(bit_val_o),
        .bit_we_o(bit_we_o), .pc_o(pc_o), .pc_we_o(pc_we_o), .done_o(done_o)
    );

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d of %0d compares", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Unused sources carry the inverse so a wrong operand select shows up
    task automatic go(input logic [7:0] op, b2, b3, input logic [15:0] pc,
                      input logic [7:0] a, d, input logic c, ac, bm, bl, pt, output int cyc);
        cyc = 0;
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        opcode_i <= op;
        byte2_i <= b2;
        byte3_i <= b3;
        pc_i <= pc;
        acc_i <= a;
        wreg_i <= (op[7:3] == `CCB_OP_CMP_REG_HI) ? d : ~d;
        ind_data_i <= (op[7:1] == `CCB_OP_CMP_IND_HI) ? d : ~d;
        dir_data_i <= (op == `CCB_OP_CMP_ACC_DIR) ? d : ~d;
        carry_i <= c;
        aux_carry_flag_i <= ac;
        bit_mem_i <= bm;
        bit_latch_i <= bl;
        bit_is_port_i <= pt;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        do begin
            @(posedge ref_clk_i);
            #1;
            cyc++;
        end while (done_o !== 1'b1 && cyc < 100);
        if (done_o !== 1'b1) begin
            n_fail++;
            $display("FAIL t=%0t no completion", $time);
            complete_run();
        end
    endtask

    task automatic t_cmp();
        logic [7:0]  fo [6] = '{`CCB_OP_CMP_ACC_DIR, `CCB_OP_CMP_ACC_IMM,
                                8'hBD, 8'hB7, 8'hB6, 8'hB8};
        logic [7:0]  av [3] = '{8'h34, 8'h60, 8'hC0};
        logic [7:0]  bv [3] = '{8'h60, 8'h60, 8'h20};
        logic [7:0]  rv [3] = '{8'h10, 8'hF0, 8'hF0};
        logic [15:0] pe;
        int          cyc;
        for (int f = 0; f < 6; f++) begin
            for (int k = 0; k < 3; k++) begin
                go(fo[f], (f == 0) ? 8'h30 : bv[k], rv[k], 16'hFFF0, (f < 2) ? av[k] : 8'h5A,
                   (f == 0) ? bv[k] : av[k], !(av[k] < bv[k]), 1'b1, 1'b0, 1'b0, 1'b0, cyc);
                pe = 16'hFFF3 + ((av[k] != bv[k]) ? {{8{rv[k][7]}}, rv[k]} : 16'h0000);
                chk(pc_o, pe);
                chk(carry_o, av[k] < bv[k]);
                chk(16'(cyc), 16'(2 * MC));
                chk({pc_we_o, carry_we_o, acc_we_o, bit_we_o}, 4'hC);
                chk({working_register_o, pointer_register_o}, {fo[f][2:0], fo[f][0]});
                if (f == 0) chk(dir_addr_o, 8'h30);
            end
        end
    endtask

    task automatic t_bits();
        int cyc;
        go(`CCB_OP_CLR_ACC, 8'h00, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0,
           1'b0, cyc);
        chk(acc_o, 8'h00);
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b100, 13'(MC)});
        go(`CCB_OP_INV_ACC, 8'h00, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0,
           1'b0, cyc);
        chk(acc_o, 8'hA3);
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b100, 13'(MC)});
        go(`CCB_OP_CLR_CARRY, 8'h00, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1,
           1'b0, cyc);
        chk(carry_o, 1'b0);
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b010, 13'(MC)});
        go(`CCB_OP_INV_CARRY, 8'h00, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1,
           1'b0, cyc);
        chk(carry_o, 1'b1);
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b010, 13'(MC)});
        go(`CCB_OP_CLR_BIT, 8'h92, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1,
           1'b1, cyc);
        chk({bit_addr_o, bit_val_o}, {8'h92, 1'b0});
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b001, 13'(MC)});
        // Pin and latch disagree so the source of the old value is visible
        go(`CCB_OP_INV_BIT, 8'h90, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1,
           1'b1, cyc);
        chk({bit_addr_o, bit_val_o}, {8'h90, 1'b0});
        go(`CCB_OP_INV_BIT, 8'h20, 8'h00, 16'h0100, 8'h5C, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1,
           1'b0, cyc);
        chk({bit_addr_o, bit_val_o}, {8'h20, 1'b1});
        chk({acc_we_o, carry_we_o, bit_we_o, 13'(cyc)}, {3'b001, 13'(MC)});
    endtask

    task automatic t_adj();
        // Last case: low fix carries out of bit 7 and must set carry
        logic [7:0] av [7] = '{8'hBE, 8'hC9, 8'h99, 8'h12, 8'h9A, 8'h00, 8'hFA};
        logic [7:0] ev [7] = '{8'h24, 8'h29, 8'hF9, 8'h18, 8'h00, 8'h66, 8'h60};
        logic       cv [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic       hv [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic       ec [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
        int         cyc;
        for (int k = 0; k < 7; k++) begin
            go(`CCB_OP_DEC_ADJ, 8'h00, 8'h00, 16'h0200, av[k], 8'h00, cv[k], hv[k], 1'b0, 1'b0,
               1'b0, cyc);
            chk({acc_o, carry_o}, {ev[k], ec[k]});
            chk({acc_we_o, carry_we_o, bit_we_o, pc_we_o, 12'(cyc)}, {4'b1100, 12'(MC)});
        end
    endtask

    // Unknown opcode is ignored: unit stays idle
    task automatic t_refuse();
        @(posedge ref_clk_i);
        start_i <= 1'b1;
        opcode_i <= 8'h00;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        repeat (2 * MC) @(posedge ref_clk_i);
        #1;
        chk({ready_o, done_o}, 2'b10);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk({ready_o, done_o, acc_we_o, pc_we_o}, 4'h8);
        t_cmp();
        t_bits();
        t_adj();
        t_refuse();
        complete_run();
    end
endmodule // ccb_core_tb
`default_nettype wire
